// ---- design/pdm_consts.vh ----
// Constants for the power-down mode controller.
// Function
// - SLEEP picks sleep, subsleep, standby or direct
// - Second gate bit 7 stops serial port B
// - Second gate bits 6..0 read zero
// - Sleep halts CPU, peripherals keep divided clock
// - Enabled unmasked interrupt ends sleep
// - Reset pin low resets CPU, ends sleep
// - Standby stops clocks, ports go high impedance
// - Standby wake restarts clock, waits, then interrupts
// - Subsleep halts oscillator, ports hold state
// - Subsleep wake restarts oscillator after wait; the code restarts it as the wait begins
// - Low-power modes reset timer V, serial, converter
// - Transition with subsleep select resets those modules
// - New divider applies only at SLEEP
// - Direct transition goes active then interrupts
// - Disabled direct interrupt enters sleep instead
// - Masked direct attempt enters unwakeable sleep
// - Gate bit one stops module clock
// - Divider codes: 0XX, /8, /16, /32, /64
`ifndef PDM_CONSTS_VH
`define PDM_CONSTS_VH
`define PDM_OFF_CTRL1      8'h00
`define PDM_OFF_CTRL2      8'h04
`define PDM_OFF_GATE1      8'h08
`define PDM_OFF_GATE2      8'h0C
`define PDM_OFF_STATUS     8'h10
`define PDM_C1_STBY_BIT    7
`define PDM_C1_STS_LSB     4
`define PDM_C2_SLEEP_TARGET_SELECT_BIT   7
`define PDM_C2_DIRECT_TRANSITION_ON_BIT    5
`define PDM_C2_MA_LSB      2
`define PDM_GATE1_MASK     8'h3E
`define PDM_GATE2_MASK     8'h80
`define PDM_GATE2_SERB_BIT 7
`define PDM_RESET_BYTE     8'h00
`define PDM_WAIT_BASE      16'h0010
`define PDM_CTRL1_MASK     8'hF0
`define PDM_CTRL2_MASK     8'hBC
`define PDM_DIV8_LAST      6'h07
`define PDM_DIV16_LAST     6'h0F
`define PDM_DIV32_LAST     6'h1F
`define PDM_DIV64_LAST     6'h3F
`endif

// ---- design/pdm_clk_div.v ----
// Divider producing the one-cycle operating clock enable.
`timescale 1ns/1ps
`include "pdm_consts.vh"
module pdm_clk_div #(
   parameter WIDTH = 6
) (
   input  wire       clk_in,
   input  wire       reset_in,
   input  wire [2:0] sel_in,
   output wire       tick_out
);
   reg [WIDTH-1:0] count;
   reg [WIDTH-1:0] limit;

   // Divider code maps to terminal count.
   // divider code decode
   always @* begin
      case (sel_in)
         3'h4:    limit = `PDM_DIV8_LAST;
         3'h5:    limit = `PDM_DIV16_LAST;
         3'h6:    limit = `PDM_DIV32_LAST;
         3'h7:    limit = `PDM_DIV64_LAST;
         default: limit = 6'h00;
      endcase
   end

   // Free-running counter, pulses once per period.
   always @(posedge clk_in) begin
      if (reset_in || count >= limit) begin
         count <= {WIDTH{1'b0}};
      end else begin
         count <= count + 1'b1;
      end
   end

   assign tick_out = (count >= limit);
endmodule // pdm_clk_div

// ---- design/pdm_power_ctrl.v ----
// Power-down mode controller with AXI4-Lite registers.
//
// The register offsets and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
`include "pdm_consts.vh"
module pdm_power_ctrl (
   input  wire        clk_in,
   input  wire        reset_in,
   input  wire        ext_reset_pin_n_in,
   input  wire        sleep_exec_in,
   input  wire        int_mask_in,
   input  wire        int_req_in,
   input  wire        direct_int_en_in,
   input  wire [31:0] s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output wire        s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output wire        s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [31:0] s_axi_araddr,
   input  wire        s_axi_arvalid,
   output wire        s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   output reg         cpu_run_out,
   output reg         cpu_reset_out,
   output reg         exc_start_out,
   output reg         direct_exc_out,
   output reg         osc_run_out,
   output reg         periph_clk_en_out,
   output reg         port_hiz_out,
   output reg         port_hold_out,
   output reg         low_reset_out,
   output reg  [4:0]  gate1_stop_out,
   output reg         serial_b_stop_out
);
   // One-hot mode states; the wake state covers the settling wait.
   // Status reads show these codes directly, so they stay one-hot.
   localparam S_ACTIVE = 5'h01;
   localparam S_SLEEP  = 5'h02;
   localparam S_SUBSLP = 5'h04;
   localparam S_STBY   = 5'h08;
   localparam S_WAKE   = 5'h10;

   // Mode state and the lock taken by a masked direct attempt.
   reg [4:0]  state;
   reg        sleep_locked;
   // Software-visible registers; reserved bits always hold zero.
   reg [7:0]  ctrl1;
   reg [7:0]  ctrl2;
   reg [7:0]  gate1;
   reg [7:0]  gate2;
   // Divider in force; it only follows the control register at a SLEEP.
   reg [2:0]  ma_live;
   // Settling countdown, loaded when a wake-up is accepted.
   reg [15:0] wait_cnt;
   // Write channel holding registers, since address and data may arrive apart.
   reg [31:0] aw_addr;
   reg        aw_held;
   reg [31:0] w_data;
   reg [3:0]  w_strb;
   reg        w_held;
   // Combinational helpers.
   reg [31:0] next_rdata;
   reg [15:0] wait_load;
   wire       div_tick;
   wire       wake_ok;
   wire       do_write;

   // A locked sleep ignores every interrupt; only reset_in or the reset pin clears it.
   // Ready is withheld while a response waits, so one write is in flight.
   // Read ready drops while read data wait, which keeps rdata stable.
   assign wake_ok       = int_req_in && !int_mask_in && !sleep_locked;
   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready  = !w_held && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;
   assign do_write      = aw_held && w_held && !s_axi_bvalid;

   // Operating clock enable at the latched divider setting.
   // A shorter period takes effect at once, because the count wraps on reaching it.
   // Ticks only gate peripheral clocks; the controller runs every cycle.
   pdm_clk_div #(
      .WIDTH (6)
   ) u_div (
      .clk_in   (clk_in),
      .reset_in (reset_in),
      .sel_in   (ma_live),
      .tick_out (div_tick)
   );

   // Settling wait length from the wait select field.
   // A shift keeps every choice a power of two, so no table is needed.
   // The count is in system clocks and only has to cover settling.
   always @* begin
      wait_load = `PDM_WAIT_BASE << ctrl1[`PDM_C1_STS_LSB +: 3];
   end

   // Write address and data are captured independently.
   // Holding each half lets the master offer them in either order.
   // Both holds clear together once the write is performed.
   always @(posedge clk_in) begin
      if (reset_in) begin
         aw_held <= 1'b0;
         w_held  <= 1'b0;
         aw_addr <= 32'h00000000;
         w_data  <= 32'h00000000;
         w_strb  <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end else if (do_write) begin
            aw_held <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end else if (do_write) begin
            w_held <= 1'b0;
         end
      end
   end

   // Register writes and the write response.
   // Only byte lane 0 carries register bits; the other lanes are ignored.
   // Unmapped offsets written through lane 0 answer with an error and change nothing.
   always @(posedge clk_in) begin
      if (reset_in) begin
         ctrl1        <= `PDM_RESET_BYTE;
         ctrl2        <= `PDM_RESET_BYTE;
         gate1        <= `PDM_RESET_BYTE;
         gate2        <= `PDM_RESET_BYTE;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= 2'h0;
      end else begin
         if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= 2'h0;
            if (w_strb[0]) begin
               case (aw_addr[7:0])
                  `PDM_OFF_CTRL1: ctrl1 <= w_data[7:0] & `PDM_CTRL1_MASK;
                  `PDM_OFF_CTRL2: ctrl2 <= w_data[7:0] & `PDM_CTRL2_MASK;
                  `PDM_OFF_GATE1: gate1 <= w_data[7:0] & `PDM_GATE1_MASK;
                  `PDM_OFF_GATE2: gate2 <= w_data[7:0] & `PDM_GATE2_MASK;
                  `PDM_OFF_STATUS: ;
                  default: s_axi_bresp <= 2'h2;
               endcase
            end
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Read data mux, status shows mode and live divider.
   // Unused addresses read zero; the response code flags them.
   always @* begin
      case (s_axi_araddr[7:0])
         `PDM_OFF_CTRL1:  next_rdata = {24'h000000, ctrl1};
         `PDM_OFF_CTRL2:  next_rdata = {24'h000000, ctrl2};
         `PDM_OFF_GATE1:  next_rdata = {24'h000000, gate1};
         `PDM_OFF_GATE2:  next_rdata = {24'h000000, gate2};
         `PDM_OFF_STATUS: next_rdata = {23'h000000, sleep_locked, ma_live, state};
         default:         next_rdata = 32'h00000000;
      endcase
   end

   // Read response.
   // Read data are registered so they stay put while rvalid waits.
   // Misaligned or out-of-range reads also answer with an error.
   always @(posedge clk_in) begin
      if (reset_in) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h00000000;
         s_axi_rresp  <= 2'h0;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= next_rdata;
         s_axi_rresp  <= (s_axi_araddr[7:0] > `PDM_OFF_STATUS ||
                          s_axi_araddr[1:0] != 2'h0) ? 2'h2 : 2'h0;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // Mode sequencer.
   // Pulse outputs default low each cycle and are raised for one edge.
   // The reset pin outranks every mode, a locked sleep included.
   always @(posedge clk_in) begin
      exc_start_out  <= 1'b0;
      direct_exc_out <= 1'b0;
      low_reset_out  <= 1'b0;
      if (reset_in) begin
         state         <= S_ACTIVE;
         sleep_locked  <= 1'b0;
         ma_live       <= 3'h0;
         wait_cnt      <= 16'h0000;
         cpu_reset_out <= 1'b1;
      end else if (!ext_reset_pin_n_in) begin
         state         <= S_ACTIVE;
         sleep_locked  <= 1'b0;
         cpu_reset_out <= 1'b1;
         // Module resets last as long as the low-power mode shows on the ports.
         low_reset_out <= (state == S_SUBSLP) || (state == S_STBY);
      end else begin
         cpu_reset_out <= 1'b0;
         case (state)
            S_ACTIVE: begin
               // Mode choice uses the register values at the SLEEP edge.
               if (sleep_exec_in) begin
                  ma_live <= ctrl2[`PDM_C2_MA_LSB +: 3];
                  low_reset_out <= ctrl2[`PDM_C2_SLEEP_TARGET_SELECT_BIT];
                  if (ctrl2[`PDM_C2_DIRECT_TRANSITION_ON_BIT]) begin
                     if (int_mask_in) begin
                        state        <= S_SLEEP;
                        sleep_locked <= 1'b1;
                     end else if (!direct_int_en_in) begin
                        state <= S_SLEEP;
                     end else begin
                        direct_exc_out <= 1'b1;
                     end
                  end else if (ctrl1[`PDM_C1_STBY_BIT]) begin
                     state <= S_STBY;
                  end else if (ctrl2[`PDM_C2_SLEEP_TARGET_SELECT_BIT]) begin
                     state <= S_SUBSLP;
                  end else begin
                     state <= S_SLEEP;
                  end
               end
            end
            S_SLEEP: begin
               if (wake_ok) begin
                  state         <= S_ACTIVE;
                  exc_start_out <= 1'b1;
               end
            end
            S_SUBSLP, S_STBY: begin
               low_reset_out <= 1'b1;
               // The counter is loaded here so the wait starts with the oscillator.
               // load settling counter
               if (wake_ok) begin
                  state    <= S_WAKE;
                  wait_cnt <= wait_load;
               end
            end
            S_WAKE: begin
               // Counting down to zero gives the load plus one cycle of settling.
               // release after wait expires
               if (wait_cnt == 16'h0000) begin
                  state         <= S_ACTIVE;
                  exc_start_out <= 1'b1;
               end else begin
                  wait_cnt <= wait_cnt - 16'h0001;
               end
            end
            // Any illegal code falls back to active.
            default: state <= S_ACTIVE;
         endcase
      end
   end

   // Clock, port and gating controls per mode.
   // Mode outputs follow the state one edge later, all from the same state value,
   // so every mode output changes together.
   always @(posedge clk_in) begin
      if (reset_in) begin
         cpu_run_out       <= 1'b1;
         osc_run_out       <= 1'b1;
         periph_clk_en_out <= 1'b0;
         port_hiz_out      <= 1'b0;
         port_hold_out     <= 1'b0;
         gate1_stop_out    <= 5'h00;
         serial_b_stop_out <= 1'b0;
      end else begin
         cpu_run_out       <= (state == S_ACTIVE);
         osc_run_out       <= (state != S_SUBSLP) && (state != S_STBY);
         periph_clk_en_out <= div_tick && (state == S_ACTIVE || state == S_SLEEP);
         // Ports float only in standby; in subsleep they hold their levels.
         port_hiz_out      <= (state == S_STBY);
         port_hold_out     <= (state == S_SUBSLP);
         // Gate bits pass through a flop so module clocks switch cleanly.
         // gate bits stop clocks
         gate1_stop_out    <= gate1[5:1];
         serial_b_stop_out <= gate2[`PDM_GATE2_SERB_BIT];
      end
   end
endmodule // pdm_power_ctrl

// ---- sim/pdm_chk.sv ----
// Port checker for the power-down mode controller.
`timescale 1ns/1ps
module pdm_chk (
   input logic clk_in,
   input logic reset_in,
   input logic ext_reset_pin_n_in,
   input logic sleep_exec_in,
   input logic int_mask_in,
   input logic s_axi_bvalid,
   input logic s_axi_bready,
   input logic cpu_run_out,
   input logic cpu_reset_out,
   input logic exc_start_out,
   input logic direct_exc_out,
   input logic periph_clk_en_out,
   input logic port_hiz_out,
   input logic port_hold_out,
   input logic low_reset_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (reset_in);
   a_pin_reset: assert property (
      !ext_reset_pin_n_in |=> cpu_reset_out) else $error("Pin reset missed.");
   a_standby_halt: assert property (
      port_hiz_out |-> !cpu_run_out && !periph_clk_en_out) else $error("Standby runs.");
   a_subsleep_halt: assert property (
      port_hold_out |-> !cpu_run_out && !periph_clk_en_out) else $error("Subsleep runs.");
   a_low_reset: assert property (
      port_hiz_out || port_hold_out |-> low_reset_out) else $error("Modules not reset.");
   a_exc_pulse: assert property (
      exc_start_out |=> !exc_start_out) else $error("Exception start too long.");
   a_exc_unmask: assert property (
      exc_start_out |-> !$past(int_mask_in)) else $error("Masked exception start.");
   a_direct_cause: assert property (
      direct_exc_out |-> cpu_run_out && ($past(sleep_exec_in) || $past(sleep_exec_in, 2)))
      else $error("Direct exception without SLEEP.");
   a_bvalid_hold: assert property (
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("Response dropped.");
endmodule // pdm_chk
bind pdm_power_ctrl pdm_chk u_chk (.clk_in, .reset_in, .ext_reset_pin_n_in, .sleep_exec_in,
   .int_mask_in, .s_axi_bvalid, .s_axi_bready, .cpu_run_out, .cpu_reset_out, .exc_start_out,
   .direct_exc_out, .periph_clk_en_out, .port_hiz_out, .port_hold_out, .low_reset_out);

// ---- sim/pdm_int_src.sv ----
// Interrupt source model that keeps a request pending until serviced.
`timescale 1ns/1ps
module pdm_int_src (
   input  logic clk_in,
   input  logic reset_in,
   input  logic raise_in,
   input  logic ack_in,
   output logic irq_out
);
   // Request stays up until exception handling starts.
   // pending until serviced
   always @(posedge clk_in) begin
      if (reset_in || ack_in) begin
         irq_out <= 1'b0;
      end else if (raise_in) begin
         irq_out <= 1'b1;
      end
   end
endmodule // pdm_int_src

// ---- sim/pdm_power_ctrl_tb.sv ----
// Self-checking bench for the power-down mode controller.
`timescale 1ns/1ps
module pdm_power_ctrl_tb;
   logic        clk_in, reset_in, ext_reset_pin_n_in, sleep_exec_in, int_mask_in, raise;
   logic        direct_int_en_in, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
   logic        s_axi_arvalid, s_axi_rready;
   logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr;
   logic [3:0]  s_axi_wstrb;
   wire         int_req_in, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   wire         s_axi_rvalid, cpu_run_out, cpu_reset_out, exc_start_out, direct_exc_out;
   wire         osc_run_out, periph_clk_en_out, port_hiz_out, port_hold_out;
   wire         low_reset_out, serial_b_stop_out;
   wire  [1:0]  s_axi_bresp, s_axi_rresp;
   wire  [31:0] s_axi_rdata;
   wire  [4:0]  gate1_stop_out;
   integer      num_errors = 0, samples_checked = 0, cyc = 0, n, p0, pc = 0, dc = 0, ec = 0;
   pdm_power_ctrl u_dut (.*);
   pdm_int_src u_int (.clk_in(clk_in), .reset_in(reset_in), .raise_in(raise),
      .ack_in(exc_start_out), .irq_out(int_req_in));
   // Clock of 50 ns period.
   initial begin
      clk_in = 1'b0;
      forever #25 clk_in = ~clk_in;
   end
   // Pulse counters and the hang limit.
   always @(posedge clk_in) begin
      cyc <= cyc + 1;
      pc <= pc + periph_clk_en_out;
      dc <= dc + direct_exc_out;
      ec <= ec + exc_start_out;
      if (cyc == 20000) begin
         num_errors++;
         end_sim;
      end
   end
   task chk(input [31:0] got, input [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task wr(input [7:0] a, input [7:0] d, input [1:0] er);
      @(posedge clk_in);
      s_axi_awaddr <= {24'h0, a};
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge clk_in);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      chk(s_axi_bresp, er);
   endtask
   task rd(input [7:0] a, input [31:0] exp, input [1:0] er);
      @(posedge clk_in);
      s_axi_araddr <= {24'h0, a};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge clk_in);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      chk(s_axi_rresp, er);
      if (er == 2'h0) chk(s_axi_rdata, exp);
   endtask
   // Pulses SLEEP for one cycle, then lets the registered mode outputs settle.
   task sleep_now;
      @(posedge clk_in);
      sleep_exec_in <= 1'b1;
      @(posedge clk_in);
      sleep_exec_in <= 1'b0;
      @(posedge clk_in);
      @(posedge clk_in);
   endtask
   // Raises a request, then counts edges until exception handling starts.
   task wake(output integer k);
      @(posedge clk_in);
      raise <= 1'b1;
      @(posedge clk_in);
      raise <= 1'b0;
      k = 0;
      do begin
         @(posedge clk_in);
         k++;
      end while (!exc_start_out && k < 3000);
   endtask
   task end_sim;
      $display("comparisons=%0d mismatches=%0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // Main sequence of register and mode scenarios.
   initial begin
      {reset_in, ext_reset_pin_n_in, sleep_exec_in, int_mask_in, raise} = 5'h18;
      {direct_int_en_in, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
      {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 0;
      s_axi_wstrb = 4'hF;
      repeat (3) @(posedge clk_in);
      reset_in <= 1'b0;
      rd(8'h0C, 32'h0, 2'h0);
      rd(8'h10, 32'h01, 2'h0);
      wr(8'h0C, 8'hFF, 2'h0);
      rd(8'h0C, 32'h80, 2'h0);
      wr(8'h08, 8'hFF, 2'h0);
      // Gate outputs are registered one edge after the register write.
      @(posedge clk_in);
      chk({gate1_stop_out, serial_b_stop_out}, 32'h3F);
      wr(8'h08, 8'h00, 2'h0);
      wr(8'h0C, 8'h00, 2'h0);
      @(posedge clk_in);
      chk({gate1_stop_out, serial_b_stop_out}, 32'h0);
      wr(8'h20, 8'h55, 2'h2);
      rd(8'h20, 32'h0, 2'h2);
      wr(8'h04, 8'h10, 2'h0);
      rd(8'h10, 32'h01, 2'h0);
      sleep_now;
      rd(8'h10, 32'h82, 2'h0);
      p0 = pc;
      repeat (64) @(posedge clk_in);
      chk(pc - p0, 32'd8);
      chk(cpu_run_out, 1'b0);
      wake(n);
      chk(n <= 3, 1'b1);
      wr(8'h04, 8'h90, 2'h0);
      sleep_now;
      chk({port_hold_out, low_reset_out, osc_run_out, port_hiz_out}, 32'hC);
      wake(n);
      chk(n >= 15 && n <= 21, 1'b1);
      wr(8'h00, 8'h90, 2'h0);
      sleep_now;
      chk({port_hiz_out, low_reset_out, osc_run_out, cpu_run_out}, 32'hC);
      wake(n);
      chk(n >= 31 && n <= 37, 1'b1);
      wr(8'h00, 8'h00, 2'h0);
      wr(8'h04, 8'h3C, 2'h0);
      direct_int_en_in <= 1'b1;
      p0 = dc;
      sleep_now;
      @(posedge clk_in);
      chk(dc - p0, 32'd1);
      rd(8'h10, 32'hE1, 2'h0);
      // Divide by 64 in active mode gives two peripheral ticks in 128 cycles.
      p0 = pc;
      repeat (128) @(posedge clk_in);
      chk(pc - p0, 32'd2);
      direct_int_en_in <= 1'b0;
      sleep_now;
      rd(8'h10, 32'hE2, 2'h0);
      wake(n);
      rd(8'h10, 32'hE1, 2'h0);
      direct_int_en_in <= 1'b1;
      int_mask_in <= 1'b1;
      sleep_now;
      p0 = ec;
      wake(n);
      chk(ec - p0, 32'd0);
      chk(cpu_run_out, 1'b0);
      // pin held low four cycles to release the locked sleep
      ext_reset_pin_n_in <= 1'b0;
      repeat (4) @(posedge clk_in);
      chk(cpu_reset_out, 1'b1);
      ext_reset_pin_n_in <= 1'b1;
      repeat (4) @(posedge clk_in);
      chk({cpu_reset_out, cpu_run_out}, 32'h1);
      end_sim;
   end
endmodule // pdm_power_ctrl_tb
